// >>> hdl/fpac_map.vh
`ifndef FPAC_MAP_VH
`define FPAC_MAP_VH

// Pipeline action codes
`define FPAC_ACT_W 3
`define FPAC_ACT_NONE 3'h0
`define FPAC_ACT_INJECT 3'h1
`define FPAC_ACT_INJECT_MASQ 3'h2
`define FPAC_ACT_REDIRECT 3'h3
`define FPAC_ACT_UPEP_EXTRACT 3'h4
`define FPAC_ACT_LATE_TERM 3'h5
`define FPAC_ACT_LOOP_REW 3'h6
`define FPAC_ACT_LOOP_ANLZ 3'h7

// Pipeline points, in pipeline order; 0 means none
`define FPAC_PT_W 5
`define FPAC_PT_NONE 5'h00
`define FPAC_PT_ANLZ_FIRST 5'h01
`define FPAC_PT_CLS_MATCH 5'h05
`define FPAC_PT_INNER_SW 5'h0d
`define FPAC_PT_ANLZ_LAST 5'h0f
`define FPAC_PT_POST_ANLZ 5'h10
`define FPAC_PT_REW_FIRST 5'h11
`define FPAC_PT_REW_LAST 5'h19
`define FPAC_PT_LOOP_OFS 5'h10

// Config RAM init
`define FPAC_RAM_DEPTH 64
`define FPAC_RAM_AW 6
`define FPAC_RAM_DW 16
`define FPAC_RAM_RESET 16'h0000

`endif

// >>> hdl/fpac_ram.v
`timescale 1ns/10ps
`default_nettype none
`include "fpac_map.vh"

module fpac_ram (
  input wire clk,
  input wire we,
  input wire [`FPAC_RAM_AW-1:0] addr,
  input wire [`FPAC_RAM_DW-1:0] wdata,
  output reg [`FPAC_RAM_DW-1:0] rdata
);
  reg [`FPAC_RAM_DW-1:0] mem [0:`FPAC_RAM_DEPTH-1];

  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

// >>> hdl/fpac_stage.v
`timescale 1ns/10ps
`default_nettype none
`include "fpac_map.vh"

// Decides process/skip/stop for one stage spanning points lo..hi
module fpac_stage (
  input wire [`FPAC_PT_W-1:0] lo,
  input wire [`FPAC_PT_W-1:0] hi,
  input wire [`FPAC_PT_W-1:0] start_pt,
  input wire [`FPAC_PT_W-1:0] end_pt,
  output wire active,
  output wire [`FPAC_PT_W-1:0] first_pt,
  output wire [`FPAC_PT_W-1:0] last_pt
);
  wire start_here = (start_pt >= lo) && (start_pt <= hi);
  wire end_here = (end_pt >= lo) && (end_pt <= hi);
  wire start_later = (start_pt != `FPAC_PT_NONE) && (start_pt > hi);
  wire end_earlier = (end_pt != `FPAC_PT_NONE) && (end_pt < lo);

  assign active = !start_later && !end_earlier;
  assign first_pt = start_here ? start_pt : lo;
  assign last_pt = end_here ? end_pt : hi;
endmodule
`default_nettype wire

// >>> hdl/fpac_ctrl.v
// Functional notes
// RQ1: Plain inject starts processing at the attached point, skipping earlier stages.
// RQ2: Masquerade inject is flagged masqueraded and starts at the attached point.
// RQ3: Redirect extract stops processing at the point, then delivers to CPU.
// RQ4: CPU copy carries no point; original frame processing continues.
// RQ5: Up-endpoint extract ends processing at the attached point.
// RQ6: Late-rewrite terminate makes the rewriter end processing at the point.
// RQ7: Rewriter loop ends rewriter at point; analyzer resumes at matching point.
// RQ8: Analyzer loop ends analyzer at point; rewriter resumes at matching point.
// RQ9: Start and end points never both on the same queue side.
// RQ10: Analyzer-side start with rewriter-side end is supported.
// RQ11: Software sets RAM enable and init before analyzer configuration.
// RQ12: Hardware clears init bit when config RAM initialisation completes.
// RQ13: Injection at post-analyzer point bypasses analyzer, enters rewriter directly.
// RQ14: Point and action travel with the frame through every stage.
`timescale 1ns/10ps
`default_nettype none
`include "fpac_map.vh"

module fpac_ctrl (
  input wire CLK,
  input wire RESET_N,
  input wire IN_VALID,
  input wire [`FPAC_ACT_W-1:0] IN_ACTION,
  input wire [`FPAC_PT_W-1:0] IN_POINT,
  input wire IN_CPU_COPY,
  input wire LOOP_VALID,
  input wire [`FPAC_ACT_W-1:0] LOOP_ACTION,
  input wire [`FPAC_PT_W-1:0] LOOP_POINT,
  input wire CFG_RAM_ENABLE,
  input wire CFG_RAM_INIT_SET,
  input wire CFG_WE,
  input wire [`FPAC_RAM_AW-1:0] CFG_ADDR,
  input wire [`FPAC_RAM_DW-1:0] CFG_WDATA,
  output reg OUT_VALID,
  output reg [`FPAC_ACT_W-1:0] OUT_ACTION,
  output reg [`FPAC_PT_W-1:0] OUT_POINT,
  output reg OUT_MASQ,
  output reg OUT_ILLEGAL,
  output reg ANLZ_ACTIVE,
  output reg [`FPAC_PT_W-1:0] ANLZ_FIRST,
  output reg [`FPAC_PT_W-1:0] ANLZ_LAST,
  output reg REW_ACTIVE,
  output reg [`FPAC_PT_W-1:0] REW_FIRST,
  output reg [`FPAC_PT_W-1:0] REW_LAST,
  output reg TO_CPU,
  output reg TO_LOOP,
  output reg CPU_COPY,
  output reg CFG_RAM_INIT,
  output wire [`FPAC_RAM_DW-1:0] CFG_RDATA
);
  localparam ST_IDLE = 2'b01;
  localparam ST_INIT = 2'b10;

  // Stage index: analyzer side first, rewriter side second
  localparam NSTG = 2;
  localparam STG_ANLZ = 0;
  localparam STG_REW = 1;

  // Loop re-entry takes precedence over a new frame in the same cycle
  wire sel_loop = LOOP_VALID;
  wire any_valid = LOOP_VALID | IN_VALID;
  wire [`FPAC_ACT_W-1:0] act = sel_loop ? LOOP_ACTION : IN_ACTION;
  wire [`FPAC_PT_W-1:0] pt = sel_loop ? LOOP_POINT : IN_POINT;

  // A copy is only honoured for a frame that carries no action
  wire copy_req = !sel_loop && IN_CPU_COPY && (act == `FPAC_ACT_NONE);

  reg [`FPAC_PT_W-1:0] start_pt;
  reg [`FPAC_PT_W-1:0] end_pt;
  reg masq;
  reg to_cpu;
  reg to_loop;

  // Turns action and point into a start or an end of processing
  always @* begin
    start_pt = `FPAC_PT_NONE;
    end_pt = `FPAC_PT_NONE;
    masq = 1'b0;
    to_cpu = 1'b0;
    to_loop = 1'b0;
    if (sel_loop) begin
      case (act)
        `FPAC_ACT_LOOP_REW: begin
          start_pt = pt - `FPAC_PT_LOOP_OFS; // see RQ7
        end
        `FPAC_ACT_LOOP_ANLZ: begin
          start_pt = pt + `FPAC_PT_LOOP_OFS; // see RQ8
        end
        default: begin
          start_pt = `FPAC_PT_NONE;
        end
      endcase
    end else begin
      case (act)
        `FPAC_ACT_INJECT: begin
          start_pt = pt; // see RQ1 RQ13
        end
        `FPAC_ACT_INJECT_MASQ: begin
          start_pt = pt; // see RQ2
          masq = 1'b1; // see RQ2
        end
        `FPAC_ACT_REDIRECT, `FPAC_ACT_UPEP_EXTRACT: begin
          end_pt = pt; // see RQ3 RQ5
          to_cpu = 1'b1; // see RQ3
        end
        `FPAC_ACT_LATE_TERM: begin
          end_pt = pt; // see RQ6
          to_cpu = 1'b1;
        end
        `FPAC_ACT_LOOP_REW, `FPAC_ACT_LOOP_ANLZ: begin
          end_pt = pt; // see RQ7 RQ8
          to_loop = 1'b1;
        end
        default: begin
          // Plain frame or CPU copy: no point, full processing
          start_pt = `FPAC_PT_NONE; // see RQ4
        end
      endcase
    end
  end

  // Start and end on the same side of the queue system is refused
  wire start_anlz = (start_pt != `FPAC_PT_NONE) && (start_pt <= `FPAC_PT_ANLZ_LAST);
  wire start_rew = start_pt >= `FPAC_PT_POST_ANLZ;
  wire end_anlz = (end_pt != `FPAC_PT_NONE) && (end_pt <= `FPAC_PT_ANLZ_LAST);
  wire end_rew = end_pt >= `FPAC_PT_REW_FIRST;
  // Opposite sides stay legal, so analyzer start with rewriter end passes
  wire illegal = (start_anlz && end_anlz) || (start_rew && end_rew); // see RQ9 RQ10

  // Point range of each stage, packed with the analyzer in the low slot
  wire [`FPAC_PT_W*NSTG-1:0] stg_lo = {`FPAC_PT_REW_FIRST, `FPAC_PT_ANLZ_FIRST};
  wire [`FPAC_PT_W*NSTG-1:0] stg_hi = {`FPAC_PT_REW_LAST, `FPAC_PT_ANLZ_LAST};
  wire [NSTG-1:0] stg_act;
  wire [`FPAC_PT_W*NSTG-1:0] stg_first;
  wire [`FPAC_PT_W*NSTG-1:0] stg_last;

  // Every stage decides locally from the start and end it is handed
  genvar g;
  generate
    for (g = 0; g < NSTG; g = g + 1) begin : g_stage
      fpac_stage u_stage (
        .lo(stg_lo[g*`FPAC_PT_W +: `FPAC_PT_W]),
        .hi(stg_hi[g*`FPAC_PT_W +: `FPAC_PT_W]),
        .start_pt(start_pt),
        .end_pt(end_pt),
        .active(stg_act[g]),
        .first_pt(stg_first[g*`FPAC_PT_W +: `FPAC_PT_W]),
        .last_pt(stg_last[g*`FPAC_PT_W +: `FPAC_PT_W])
      ); // see RQ14
    end
  endgenerate

  wire anlz_act = stg_act[STG_ANLZ];
  wire rew_act = stg_act[STG_REW];
  wire [`FPAC_PT_W-1:0] anlz_first = stg_first[STG_ANLZ*`FPAC_PT_W +: `FPAC_PT_W];
  wire [`FPAC_PT_W-1:0] anlz_last = stg_last[STG_ANLZ*`FPAC_PT_W +: `FPAC_PT_W];
  wire [`FPAC_PT_W-1:0] rew_first = stg_first[STG_REW*`FPAC_PT_W +: `FPAC_PT_W];
  wire [`FPAC_PT_W-1:0] rew_last = stg_last[STG_REW*`FPAC_PT_W +: `FPAC_PT_W];

  // Late-rewrite terminate keeps the analyzer running; rewriter ends at point
  wire late = !sel_loop && (act == `FPAC_ACT_LATE_TERM);
  wire anlz_on = late ? 1'b1 : anlz_act;
  wire [`FPAC_PT_W-1:0] anlz_end = late ? `FPAC_PT_ANLZ_LAST : anlz_last;

  // Frame record: action and point travel on with the frame
  always @(posedge CLK) begin
    if (!RESET_N) begin
      OUT_VALID <= 1'b0;
      OUT_ACTION <= `FPAC_ACT_NONE;
      OUT_POINT <= `FPAC_PT_NONE;
      OUT_MASQ <= 1'b0;
      OUT_ILLEGAL <= 1'b0;
    end else begin
      OUT_VALID <= any_valid;
      if (any_valid) begin
        OUT_ACTION <= act; // see RQ14
        OUT_POINT <= pt; // see RQ14
        OUT_MASQ <= masq;
        OUT_ILLEGAL <= illegal; // see RQ9
      end
    end
  end

  // Stage spans; a refused pair runs neither stage
  always @(posedge CLK) begin
    if (!RESET_N) begin
      ANLZ_ACTIVE <= 1'b0;
      ANLZ_FIRST <= `FPAC_PT_NONE;
      ANLZ_LAST <= `FPAC_PT_NONE;
      REW_ACTIVE <= 1'b0;
      REW_FIRST <= `FPAC_PT_NONE;
      REW_LAST <= `FPAC_PT_NONE;
    end else begin
      if (any_valid) begin
        ANLZ_ACTIVE <= anlz_on && !illegal; // see RQ13
        ANLZ_FIRST <= anlz_first;
        ANLZ_LAST <= anlz_end;
        REW_ACTIVE <= rew_act && !illegal;
        REW_FIRST <= rew_first;
        REW_LAST <= rew_last; // see RQ6
      end
    end
  end

  // Where the frame goes once its processing has ended
  always @(posedge CLK) begin
    if (!RESET_N) begin
      TO_CPU <= 1'b0;
      TO_LOOP <= 1'b0;
      CPU_COPY <= 1'b0;
    end else begin
      if (any_valid) begin
        TO_CPU <= to_cpu && !illegal;
        TO_LOOP <= to_loop && !illegal;
        CPU_COPY <= copy_req; // see RQ4
      end
    end
  end

  // Configuration RAM initialisation
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`FPAC_RAM_AW-1:0] addr_q;
  reg [`FPAC_RAM_AW-1:0] addr_d;
  wire init_last = addr_q == {`FPAC_RAM_AW{1'b1}};
  wire init_go = CFG_RAM_ENABLE && CFG_RAM_INIT_SET; // see RQ11

  always @* begin
    state_d = state_q;
    addr_d = addr_q;
    case (state_q)
      ST_IDLE: begin
        if (init_go) begin
          state_d = ST_INIT;
          addr_d = {`FPAC_RAM_AW{1'b0}};
        end
      end
      ST_INIT: begin
        addr_d = addr_q + 1'b1;
        if (init_last) begin
          state_d = ST_IDLE; // see RQ12
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      state_q <= ST_IDLE;
      addr_q <= {`FPAC_RAM_AW{1'b0}};
      CFG_RAM_INIT <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      CFG_RAM_INIT <= (state_d == ST_INIT); // see RQ12
    end
  end

  wire in_init = state_q == ST_INIT;
  wire ram_we = in_init || (CFG_WE && CFG_RAM_ENABLE && !CFG_RAM_INIT);

  fpac_ram u_ram (
    .clk(CLK),
    .we(ram_we),
    .addr(in_init ? addr_q : CFG_ADDR),
    .wdata(in_init ? `FPAC_RAM_RESET : CFG_WDATA),
    .rdata(CFG_RDATA)
  );
endmodule
`default_nettype wire

// >>> verification/fpac_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "fpac_map.vh"
module fpac_ctrl_monitor (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic IN_VALID,
  input wire logic [2:0] IN_ACTION,
  input wire logic [4:0] IN_POINT,
  input wire logic IN_CPU_COPY,
  input wire logic LOOP_VALID,
  input wire logic CFG_RAM_ENABLE,
  input wire logic CFG_RAM_INIT_SET,
  input wire logic OUT_VALID,
  input wire logic OUT_MASQ,
  input wire logic OUT_ILLEGAL,
  input wire logic ANLZ_ACTIVE,
  input wire logic [4:0] ANLZ_FIRST,
  input wire logic REW_ACTIVE,
  input wire logic [4:0] REW_FIRST,
  input wire logic TO_CPU,
  input wire logic TO_LOOP,
  input wire logic CPU_COPY,
  input wire logic CFG_RAM_INIT
);
  logic [6:0] n_q;
  wire fi = IN_VALID && !LOOP_VALID;
  // Counts consecutive cycles of a running init
  always @(posedge CLK) begin
    if (!RESET_N || !CFG_RAM_INIT) n_q <= 7'h00;
    else n_q <= n_q + 7'h01;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  frame_lat_a: assert property ((IN_VALID || LOOP_VALID) |=> OUT_VALID)
    else $error("answer missing");
  no_frame_a: assert property (!(IN_VALID || LOOP_VALID) |=> !OUT_VALID)
    else $error("spurious answer");
  refuse_a: assert property (OUT_ILLEGAL |-> !ANLZ_ACTIVE && !REW_ACTIVE && !TO_CPU && !TO_LOOP)
    else $error("illegal pair acted on");
  inj_start_a: assert property (fi && IN_ACTION == `FPAC_ACT_INJECT && IN_POINT == 5'h05
    |=> ANLZ_ACTIVE && ANLZ_FIRST == $past(IN_POINT))
    else $error("inject start wrong");
  masq_flag_a: assert property (fi && IN_ACTION == `FPAC_ACT_INJECT_MASQ |=> OUT_MASQ)
    else $error("masquerade lost");
  bypass_a: assert property (fi && IN_ACTION == `FPAC_ACT_INJECT && IN_POINT == 5'h10
    |=> !ANLZ_ACTIVE && REW_FIRST == 5'h11)
    else $error("analyzer not bypassed");
  copy_only_a: assert property (fi && IN_ACTION == 3'h0 && IN_CPU_COPY |=> CPU_COPY && !TO_CPU)
    else $error("copy handled wrong");
  xtr_cpu_a: assert property (fi && IN_ACTION == `FPAC_ACT_REDIRECT |=> TO_CPU)
    else $error("extract not to cpu");
  init_go_a: assert property (CFG_RAM_ENABLE && CFG_RAM_INIT_SET && !CFG_RAM_INIT
    |=> CFG_RAM_INIT)
    else $error("init not started");
  init_len_a: assert property ($fell(CFG_RAM_INIT) |-> n_q == 7'd64)
    else $error("init length wrong");
  cover property (fi && IN_ACTION == `FPAC_ACT_INJECT);
  cover property (LOOP_VALID);
  cover property ($fell(CFG_RAM_INIT));
endmodule
`default_nettype wire

// >>> verification/fpac_sw_model.sv
`timescale 1ns/10ps
`default_nettype none
module fpac_sw_model (
  input wire logic clk,
  input wire logic go,
  input wire logic init_busy,
  output logic ram_en,
  output logic init_set,
  output logic we,
  output logic [5:0] addr,
  output logic [15:0] wdata,
  output logic done
);
  int n;
  initial begin
    {ram_en, init_set, we, done} = 4'h0;
    addr = 6'h00;
    wdata = 16'h0000;
    forever begin
      @(posedge clk);
      if (go) begin
        ram_en <= 1'b1;
        init_set <= 1'b1;
        @(posedge clk);
        init_set <= 1'b0;
        repeat (3) @(posedge clk);
        n = 0;
        while (init_busy !== 1'b0 && n < 200) begin
          @(posedge clk);
          n++;
        end
        // Configuration only after init has finished
        we <= 1'b1;
        addr <= 6'h03;
        wdata <= 16'hbeef;
        @(posedge clk);
        we <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/fpac_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "fpac_map.vh"
module fpac_ctrl_tb;
  logic CLK, RESET_N, IN_VALID, IN_CPU_COPY, LOOP_VALID, go;
  logic [2:0] IN_ACTION, LOOP_ACTION;
  logic [4:0] IN_POINT, LOOP_POINT;
  wire CFG_RAM_ENABLE, CFG_RAM_INIT_SET, CFG_WE, done;
  wire [5:0] CFG_ADDR;
  wire [15:0] CFG_WDATA, CFG_RDATA;
  wire OUT_VALID, OUT_MASQ, OUT_ILLEGAL, ANLZ_ACTIVE, REW_ACTIVE, TO_CPU, TO_LOOP;
  wire CPU_COPY, CFG_RAM_INIT;
  wire [2:0] OUT_ACTION;
  wire [4:0] OUT_POINT, ANLZ_FIRST, ANLZ_LAST, REW_FIRST, REW_LAST;
  int miscompares = 0;
  int compares = 0;
  fpac_ctrl u_dut (.CLK, .RESET_N, .IN_VALID, .IN_ACTION, .IN_POINT, .IN_CPU_COPY,
    .LOOP_VALID, .LOOP_ACTION, .LOOP_POINT, .CFG_RAM_ENABLE, .CFG_RAM_INIT_SET, .CFG_WE,
    .CFG_ADDR, .CFG_WDATA, .OUT_VALID, .OUT_ACTION, .OUT_POINT, .OUT_MASQ, .OUT_ILLEGAL,
    .ANLZ_ACTIVE, .ANLZ_FIRST, .ANLZ_LAST, .REW_ACTIVE, .REW_FIRST, .REW_LAST, .TO_CPU,
    .TO_LOOP, .CPU_COPY, .CFG_RAM_INIT, .CFG_RDATA);
  fpac_sw_model u_sw (.clk(CLK), .go(go), .init_busy(CFG_RAM_INIT), .ram_en(CFG_RAM_ENABLE),
    .init_set(CFG_RAM_INIT_SET), .we(CFG_WE), .addr(CFG_ADDR), .wdata(CFG_WDATA), .done(done));
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  task chk(input string s, input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task fr(input logic [2:0] a, input logic [4:0] p, input logic c, input logic l);
    @(posedge CLK);
    IN_VALID <= !l;
    LOOP_VALID <= l;
    {IN_ACTION, LOOP_ACTION} <= {a, a};
    {IN_POINT, LOOP_POINT} <= {p, p};
    IN_CPU_COPY <= c;
    @(posedge CLK);
    {IN_VALID, LOOP_VALID, IN_CPU_COPY} <= 3'h0;
    #1;
    chk("valid", OUT_VALID, 1);
    chk("action", OUT_ACTION, a);
    if (!l) chk("point", OUT_POINT, p);
  endtask
  task t_inject;
    fr(`FPAC_ACT_INJECT, 5'h05, 0, 0);
    chk("anlz_first", ANLZ_FIRST, 5'h05);
    chk("rew_last", REW_LAST, 5'h19);
    chk("illegal", OUT_ILLEGAL, 0);
    fr(`FPAC_ACT_INJECT, 5'h10, 0, 0);
    chk("anlz_act", ANLZ_ACTIVE, 0);
    chk("rew_first", REW_FIRST, 5'h11);
    fr(`FPAC_ACT_INJECT_MASQ, 5'h05, 0, 0);
    chk("masq", OUT_MASQ, 1);
    $display("inject test done");
  endtask
  task t_extract;
    fr(`FPAC_ACT_REDIRECT, 5'h0d, 0, 0);
    chk("to_cpu", TO_CPU, 1);
    chk("anlz_last", ANLZ_LAST, 5'h0d);
    fr(`FPAC_ACT_NONE, 5'h00, 1, 0);
    chk("copy", CPU_COPY, 1);
    chk("rew_act", REW_ACTIVE, 1);
    fr(`FPAC_ACT_UPEP_EXTRACT, 5'h15, 0, 0);
    chk("rew_last", REW_LAST, 5'h15);
    fr(`FPAC_ACT_LATE_TERM, 5'h15, 0, 0);
    chk("rew_last", REW_LAST, 5'h15);
    chk("anlz_last", ANLZ_LAST, 5'h0f);
    chk("to_cpu", TO_CPU, 1);
    $display("extract test done");
  endtask
  task t_loop;
    fr(`FPAC_ACT_LOOP_ANLZ, 5'h05, 0, 0);
    chk("to_loop", TO_LOOP, 1);
    chk("anlz_last", ANLZ_LAST, 5'h05);
    fr(`FPAC_ACT_LOOP_ANLZ, 5'h05, 0, 1);
    chk("rew_first", REW_FIRST, 5'h15);
    fr(`FPAC_ACT_LOOP_REW, 5'h15, 0, 0);
    chk("rew_last", REW_LAST, 5'h15);
    fr(`FPAC_ACT_LOOP_REW, 5'h15, 0, 1);
    chk("anlz_first", ANLZ_FIRST, 5'h05);
    $display("loop test done");
  endtask
  task t_init;
    int k;
    k = 0;
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    while (CFG_RAM_INIT !== 1'b1 && k < 100) begin
      @(posedge CLK);
      #1;
      k++;
    end
    k = 0;
    while (CFG_RAM_INIT === 1'b1 && k < 200) begin
      @(posedge CLK);
      #1;
      k++;
    end
    chk("init_len", k, 64);
    repeat (10) @(posedge CLK);
    #1;
    chk("rdata", CFG_RDATA, 16'hbeef);
    chk("sw_done", done, 1);
    $display("init test done");
  endtask
  initial begin
    {RESET_N, IN_VALID, IN_CPU_COPY, LOOP_VALID, go} = 5'h0;
    {IN_ACTION, LOOP_ACTION, IN_POINT, LOOP_POINT} = 16'h0000;
    repeat (3) @(posedge CLK);
    RESET_N <= 1'b1;
    t_inject;
    t_extract;
    t_loop;
    @(posedge CLK);
    t_init;
    report_and_stop;
  end
  initial begin
    repeat (2000) @(posedge CLK);
    miscompares++;
    report_and_stop;
  end
endmodule
bind fpac_ctrl fpac_ctrl_monitor u_mon (.CLK, .RESET_N, .IN_VALID, .IN_ACTION, .IN_POINT,
  .IN_CPU_COPY, .LOOP_VALID, .CFG_RAM_ENABLE, .CFG_RAM_INIT_SET, .OUT_VALID, .OUT_MASQ,
  .OUT_ILLEGAL, .ANLZ_ACTIVE, .ANLZ_FIRST, .REW_ACTIVE, .REW_FIRST, .TO_CPU, .TO_LOOP,
  .CPU_COPY, .CFG_RAM_INIT);
`default_nettype wire
